// ==== src/cicc_top.v ====
`include "cicc_defs.vh"
`default_nettype none

module cicc_top (
    // Clock and reset
    input wire REF_CLK,
    input wire RST_B,
    // Register port
    input wire [3:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Instruction issue
    input wire [13:0] INSTR,
    input wire INSTR_VALID,
    output wire INSTR_READY,
    // File register side
    output reg [6:0] FILE_ADDR,
    input wire [7:0] FILE_RDATA,
    output reg [7:0] FILE_WDATA,
    output reg FILE_WE,
    // Stack and watchdog
    output reg [12:0] STACK_HEAD,
    output reg STACK_PUSH,
    output reg WDT_CLEAR,
    output reg PRESCALER_CLEAR,
    // Program counter and flags
    output reg [12:0] PC,
    output reg NULL_FLAG,
    output reg EXPIRY_FLAG,
    output reg SLEEP_FLAG
);
    wire rst_b;
    reg [7:0] latch_r;
    reg [7:0] acc_r;
    reg busy_r;
    reg [13:0] sw_instr_r;
    reg sw_go_r;
    reg [6:0] file_wa_r;
    wire [13:0] op;
    wire go;
    wire is_call;
    wire is_zfr;
    wire is_clra;
    wire is_inv;
    wire is_kick;
    wire [7:0] inv_val;

    cicc_sync u_sync (
        .clk(REF_CLK),
        .rst_b_in(RST_B),
        .rst_b_out(rst_b)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Software write to the instruction register issues one too
    assign op = sw_go_r ? sw_instr_r : INSTR;
    // One file port: no new opcode while a write-back holds the address
    assign go = (sw_go_r | INSTR_VALID) & ~busy_r & ~FILE_WE;
    assign INSTR_READY = ~busy_r & ~sw_go_r & ~FILE_WE;
    assign is_call = (op & `CICC_CALL_MASK) == `CICC_CALL_CODE;
    assign is_zfr = (op & `CICC_ZFR_MASK) == `CICC_ZFR_CODE;
    assign is_clra = op == `CICC_CLRA_CODE;
    assign is_inv = (op & `CICC_INV_MASK) == `CICC_INV_CODE;
    assign is_kick = op == `CICC_KICK_CODE;
    assign inv_val = ~FILE_RDATA;

    // File address must be valid during decode so the read is combinational
    always @* begin
        FILE_ADDR = FILE_WE ? file_wa_r : op[`CICC_FA_HI:0];
    end

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    always @(posedge REF_CLK or negedge rst_b) begin
        if (!rst_b) begin
            PC <= 13'h0000;
            acc_r <= `CICC_ZERO8;
            busy_r <= 1'b0;
            NULL_FLAG <= 1'b0;
            EXPIRY_FLAG <= 1'b1;
            SLEEP_FLAG <= 1'b1;
            STACK_HEAD <= 13'h0000;
            STACK_PUSH <= 1'b0;
            FILE_WDATA <= `CICC_ZERO8;
            FILE_WE <= 1'b0;
            WDT_CLEAR <= 1'b0;
            PRESCALER_CLEAR <= 1'b0;
            file_wa_r <= 7'h00;
        end else begin
            STACK_PUSH <= 1'b0;
            FILE_WE <= 1'b0;
            WDT_CLEAR <= 1'b0;
            PRESCALER_CLEAR <= 1'b0;
            // Second cycle of a call is a bubble; flags stay put
            if (busy_r) begin
                busy_r <= 1'b0;
            end else if (go) begin
                PC <= PC + `CICC_PC_ONE;
                file_wa_r <= op[`CICC_FA_HI:0];
                if (is_call) begin
                    STACK_HEAD <= PC + `CICC_PC_ONE;
                    STACK_PUSH <= 1'b1;
                    PC <= {latch_r[`CICC_LATCH_HI:`CICC_LATCH_LO],
                        op[`CICC_K_HI:0]};
                    busy_r <= 1'b1;
                end else if (is_zfr) begin
                    FILE_WDATA <= `CICC_ZERO8;
                    FILE_WE <= 1'b1;
                    NULL_FLAG <= 1'b1;
                end else if (is_clra) begin
                    acc_r <= `CICC_ZERO8;
                    NULL_FLAG <= 1'b1;
                end else if (is_inv) begin
                    NULL_FLAG <= inv_val == `CICC_ZERO8;
                    if (op[`CICC_DEST_BIT]) begin
                        FILE_WDATA <= inv_val;
                        FILE_WE <= 1'b1;
                    end else begin
                        acc_r <= inv_val;
                    end
                end else if (is_kick) begin
                    WDT_CLEAR <= 1'b1;
                    PRESCALER_CLEAR <= 1'b1;
                    EXPIRY_FLAG <= 1'b1;
                    SLEEP_FLAG <= 1'b1;
                end
            end
            if (WR && wdata_hits_acc(ADDR)) begin
                acc_r <= WDATA;
            end
        end
    end

    function wdata_hits_acc;
        input [3:0] a;
        begin
            wdata_hits_acc = a == `CICC_REG_ACC;
        end
    endfunction

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always @(posedge REF_CLK or negedge rst_b) begin
        if (!rst_b) begin
            latch_r <= `CICC_ZERO8;
            sw_instr_r <= 14'h0000;
            sw_go_r <= 1'b0;
            RDATA <= `CICC_ZERO8;
        end else begin
            if (go) begin
                sw_go_r <= 1'b0;
            end
            if (WR) begin
                case (ADDR)
                    `CICC_REG_INSTR: begin
                        sw_instr_r <= {6'h00, WDATA};
                        sw_go_r <= 1'b1;
                    end
                    `CICC_REG_PCLO: begin
                        sw_instr_r <= {sw_instr_r[13:8], WDATA};
                    end
                    `CICC_REG_PCHI: begin
                        sw_instr_r <= {WDATA[5:0], sw_instr_r[7:0]};
                    end
                    `CICC_REG_LATCH: begin
                        latch_r <= WDATA;
                    end
                    default: begin
                        latch_r <= latch_r;
                    end
                endcase
            end
            RDATA <= `CICC_ZERO8;
            if (RD) begin
                case (ADDR)
                    `CICC_REG_LATCH: RDATA <= latch_r;
                    `CICC_REG_PCLO: RDATA <= PC[7:0];
                    `CICC_REG_PCHI: RDATA <= {3'h0, PC[12:8]};
                    `CICC_REG_ACC: RDATA <= acc_r;
                    `CICC_REG_STAT: RDATA <= {4'h0, busy_r, SLEEP_FLAG, EXPIRY_FLAG,
                        NULL_FLAG};
                    `CICC_REG_HEAD_LO: RDATA <= STACK_HEAD[7:0];
                    `CICC_REG_HEAD_HI: RDATA <= {3'h0, STACK_HEAD[12:8]};
                    default: RDATA <= `CICC_ZERO8;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ==== src/cicc_defs.vh ====
// Functional notes
// - Call pushes PC+1, loads 11-bit target
// - Call takes PC upper bits from latch
// - Call is two cycles, flags untouched
// - Zero file register writes 00h, sets null
// - Invert file register, null flag from result
// - Invert destination bit selects accumulator or file
// - Kick watchdog clears counter and prescaler
// - Kick watchdog sets expiry and sleep flags
`ifndef CICC_DEFS_VH
`define CICC_DEFS_VH

// ------------------------------------------------------------
// Opcode fields
// ------------------------------------------------------------
`define CICC_OP_W 14
`define CICC_CALL_MASK 14'h3800
`define CICC_CALL_CODE 14'h2000
`define CICC_ZFR_MASK 14'h3f80
`define CICC_ZFR_CODE 14'h0180
`define CICC_CLRA_CODE 14'h0103
`define CICC_INV_MASK 14'h3f00
`define CICC_INV_CODE 14'h0900
`define CICC_KICK_CODE 14'h0064
`define CICC_DEST_BIT 7
`define CICC_FA_HI 6
`define CICC_K_HI 10
`define CICC_LATCH_HI 4
`define CICC_LATCH_LO 3

// ------------------------------------------------------------
// Widths and values
// ------------------------------------------------------------
`define CICC_PC_W 13
`define CICC_FA_W 7
`define CICC_ZERO8 8'h00
`define CICC_PC_ONE 13'h0001

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define CICC_ADDR_W 4
`define CICC_REG_INSTR 4'h0
`define CICC_REG_LATCH 4'h1
`define CICC_REG_PCLO 4'h2
`define CICC_REG_PCHI 4'h3
`define CICC_REG_ACC 4'h4
`define CICC_REG_STAT 4'h5
`define CICC_REG_HEAD_LO 4'h6
`define CICC_REG_HEAD_HI 4'h7

// Status register bits
`define CICC_ST_NULL 0
`define CICC_ST_EXPIRY 1
`define CICC_ST_SLEEP 2
`define CICC_ST_BUSY 3

`endif

// ==== src/cicc_sync.v ====
`include "cicc_defs.vh"
`default_nettype none

module cicc_sync (
    input wire clk,
    input wire rst_b_in,
    output wire rst_b_out
);
    reg s1_r;
    reg s2_r;

    always @(posedge clk or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= 1'b1;
            s2_r <= s1_r;
        end
    end

    assign rst_b_out = s2_r;
endmodule

`default_nettype wire

// ==== tb/cicc_props.sv ====
`default_nettype none
module cicc_props (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Issue and results
    input wire logic [13:0] INSTR,
    input wire logic INSTR_VALID,
    input wire logic INSTR_READY,
    input wire logic [7:0] FILE_RDATA,
    input wire logic [7:0] FILE_WDATA,
    input wire logic FILE_WE,
    input wire logic [12:0] STACK_HEAD,
    input wire logic STACK_PUSH,
    input wire logic WDT_CLEAR,
    input wire logic PRESCALER_CLEAR,
    input wire logic [12:0] PC,
    input wire logic NULL_FLAG,
    input wire logic EXPIRY_FLAG,
    input wire logic SLEEP_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    wire logic tk = INSTR_VALID && INSTR_READY;
    wire logic cl = tk && INSTR[13:11] == 3'b100;
    wire logic zf = tk && INSTR[13:7] == 7'h03;
    wire logic ca = tk && INSTR == 14'h0103;
    wire logic iv = tk && INSTR[13:8] == 6'h09;
    wire logic kw = tk && INSTR == 14'h0064;
    call_push_a: assert property (cl |=> STACK_PUSH
        && STACK_HEAD == $past(PC) + 13'h0001) else $error("call push");
    call_target_a: assert property (cl |=> PC[10:0] == $past(INSTR[10:0]))
        else $error("call target");
    call_wait_a: assert property (cl |=> !INSTR_READY ##1 INSTR_READY)
        else $error("call length");
    call_flags_a: assert property (cl |=> $stable(NULL_FLAG))
        else $error("call flag");
    zero_file_a: assert property (zf |=> FILE_WE && FILE_WDATA == 8'h00 && NULL_FLAG)
        else $error("zero file");
    clr_acc_a: assert property (ca |=> NULL_FLAG && !FILE_WE)
        else $error("clear acc");
    inv_null_a: assert property (iv |=> NULL_FLAG == ($past(FILE_RDATA) == 8'hff))
        else $error("invert null");
    inv_dest_a: assert property (iv |=> FILE_WE == $past(INSTR[7])
        && (!FILE_WE || FILE_WDATA == ~$past(FILE_RDATA))) else $error("invert dest");
    kick_clear_a: assert property (kw |=> WDT_CLEAR && PRESCALER_CLEAR)
        else $error("kick clear");
    kick_flags_a: assert property (kw |=> EXPIRY_FLAG && SLEEP_FLAG)
        else $error("kick flags");
    cover property (cl);
    cover property (iv && INSTR[7]);
    cover property (kw);
endmodule
bind cicc_top cicc_props u_props (.REF_CLK, .RST_B, .INSTR, .INSTR_VALID, .INSTR_READY,
    .FILE_RDATA, .FILE_WDATA, .FILE_WE, .STACK_HEAD, .STACK_PUSH, .WDT_CLEAR,
    .PRESCALER_CLEAR, .PC, .NULL_FLAG, .EXPIRY_FLAG, .SLEEP_FLAG);
`default_nettype wire

// ==== tb/cicc_file_model.sv ====
`default_nettype none
module cicc_file_model (
    // File register side
    input wire logic clk,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    input wire logic we,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m [0:127];
    initial for (int i = 0; i < 128; i++) m[i] = 8'h13;
    // Read is combinational, same cycle as the address
    assign rdata = m[addr];
    always @(posedge clk) if (we) m[addr] <= wdata;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [13:0] INSTR = 14'h0000;
    logic INSTR_VALID = 1'b0;
    logic [7:0] RDATA, FILE_RDATA, FILE_WDATA;
    logic [6:0] FILE_ADDR;
    logic [12:0] STACK_HEAD, PC, pc_e;
    logic INSTR_READY, FILE_WE, STACK_PUSH, WDT_CLEAR, PRESCALER_CLEAR;
    logic NULL_FLAG, EXPIRY_FLAG, SLEEP_FLAG;
    int mismatches = 0;
    int total_checks = 0;
    cicc_top dut (.REF_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .INSTR,
        .INSTR_VALID, .INSTR_READY, .FILE_ADDR, .FILE_RDATA, .FILE_WDATA, .FILE_WE,
        .STACK_HEAD, .STACK_PUSH, .WDT_CLEAR, .PRESCALER_CLEAR, .PC, .NULL_FLAG,
        .EXPIRY_FLAG, .SLEEP_FLAG);
    cicc_file_model fm (.clk(REF_CLK), .addr(FILE_ADDR), .wdata(FILE_WDATA),
        .we(FILE_WE), .rdata(FILE_RDATA));
    always #10 REF_CLK = ~REF_CLK;
    task automatic chk(input logic [12:0] g, input logic [12:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        @(negedge REF_CLK);
        chk({5'h00, RDATA}, {5'h00, e});
    endtask
    // Returns in the first cycle after the take edge
    task automatic op(input logic [13:0] o);
        int n = 0;
        @(posedge REF_CLK);
        INSTR <= o;
        INSTR_VALID <= 1'b1;
        @(negedge REF_CLK);
        while (INSTR_READY !== 1'b1 && n < 50) begin
            n++;
            @(negedge REF_CLK);
        end
        @(posedge REF_CLK);
        INSTR_VALID <= 1'b0;
        pc_e = pc_e + 13'h0001;
        @(negedge REF_CLK);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #20us;
        mismatches++;
        end_sim;
    end
    initial begin
        pc_e = 13'h0000;
        repeat (12) @(posedge REF_CLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        wr(4'h4, 8'h5a);
        rd(4'h4, 8'h5a);
        op(14'h0103);
        chk(NULL_FLAG, 1'b1);
        rd(4'h4, 8'h00);
        wr(4'h1, 8'h18);
        op(14'h27ff);
        chk(STACK_HEAD, pc_e);
        chk(PC, 13'h1fff);
        chk({INSTR_READY, NULL_FLAG}, 2'b01);
        wr(4'h1, 8'h08);
        pc_e = 13'h1fff;
        op(14'h2000);
        chk(STACK_HEAD, 13'h0000);
        chk(PC, 13'h0800);
        pc_e = 13'h0800;
        op(14'h0905);
        chk(PC, pc_e);
        chk(NULL_FLAG, 1'b0);
        rd(4'h4, 8'hec);
        op(14'h0985);
        @(negedge REF_CLK);
        chk(fm.m[5], 8'hec);
        op(14'h01ff);
        chk(NULL_FLAG, 1'b1);
        @(negedge REF_CLK);
        chk(fm.m[127], 8'h00);
        op(14'h09ff);
        chk(NULL_FLAG, 1'b0);
        op(14'h0064);
        chk({WDT_CLEAR, PRESCALER_CLEAR}, 2'b11);
        rd(4'h5, 8'h06);
        wr(4'h0, 8'h64);
        rd(4'h5, 8'h06);
        rd(4'h8, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
